// ==== verilog/qar_pkg.sv ====
// Constants, types and layouts shared by the quad readout serial slave
package qar_pkg;

  // ----------------------------------------------------------------
  // Register addresses and field positions
  // ----------------------------------------------------------------
  localparam logic [2:0]  ADDR_CFG1       = 3'h1;
  localparam logic [2:0]  ADDR_CFG2       = 3'h2;
  localparam logic [2:0]  ADDR_ALERT      = 3'h3;
  localparam logic [2:0]  ADDR_LOW        = 3'h4;
  localparam logic [2:0]  ADDR_HIGH       = 3'h5;
  localparam int          CFG1_CRC_W_BIT  = 5;
  localparam int          CFG1_CRC_R_BIT  = 4;
  localparam int          CFG2_LANE_LSB   = 8;
  localparam int          ALERT_CRCW_BIT  = 9;
  localparam int          CMD_WR_BIT      = 15;
  localparam int          CMD_ADDR_LSB    = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_CFG1        = 12'h000;
  localparam logic [11:0] RST_CFG2        = 12'h000;
  localparam logic [11:0] RST_LOW         = 12'h800;
  localparam logic [11:0] RST_HIGH        = 12'h7ff;

  // ----------------------------------------------------------------
  // Output lane modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  LANE_TWO        = 2'b00;
  localparam logic [1:0]  LANE_ONE        = 2'b01;
  localparam logic [1:0]  LANE_FOUR       = 2'b10;

  // ----------------------------------------------------------------
  // Frame lengths and checksum
  // ----------------------------------------------------------------
  localparam logic [6:0]  LEN_FOUR        = 7'h10;
  localparam logic [6:0]  LEN_TWO         = 7'h20;
  localparam logic [6:0]  LEN_ONE         = 7'h40;
  localparam logic [6:0]  LEN_CRC         = 7'h08;
  localparam logic [4:0]  CMD_BITS        = 5'h10;
  localparam logic [4:0]  CMD_CRC_BITS    = 5'h18;
  localparam logic [7:0]  CRC_POLY        = 8'h07;
  localparam logic [6:0]  CRC_INV_BITS    = 7'h08;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          CONV_TIME_NS    = 500;
  localparam int          CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
  } qar_results_t;

  typedef struct packed {
    logic serial_out_lane_a;
    logic serial_out_lane_b;
    logic serial_out_lane_c;
    logic serial_out_lane_d;
  } qar_lanes_t;

  typedef struct packed {
    logic       crc_write_en;
    logic       crc_read_en;
    logic [1:0] output_lane_select;
  } qar_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_CHECK = 2'b10
  } qar_state_t;

endpackage

// ==== verilog/qar_crc_serial.sv ====
// Serial checksum engine, one bit per clock, MSB first
`timescale 1ns/1ns
module qar_crc_serial #(
  parameter int MAX_BITS = 64
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                start,
  input  wire logic [MAX_BITS-1:0] data,
  input  wire logic [6:0]          nbits,
  output logic [7:0]               crc,
  output logic                     done
);
  import qar_pkg::*;

  logic [MAX_BITS-1:0] sreg_reg;
  logic [MAX_BITS-1:0] sreg_next;
  logic [6:0]          cnt_reg;
  logic [6:0]          cnt_next;
  logic [6:0]          len_reg;
  logic [6:0]          len_next;
  logic [7:0]          crc_reg;
  logic [7:0]          crc_next;
  logic                busy_reg;
  logic                busy_next;

  // ----------------------------------------------------------------
  // Next state: divide stream by polynomial, first bits inverted
  // ----------------------------------------------------------------
  always_comb
  begin
    logic in_bit;
    logic fb;
    in_bit    = sreg_reg[MAX_BITS-1] ^ (cnt_reg < CRC_INV_BITS);
    fb        = in_bit ^ crc_reg[7];
    sreg_next = sreg_reg;
    cnt_next  = cnt_reg;
    len_next  = len_reg;
    crc_next  = crc_reg;
    busy_next = busy_reg;
    if (start)
    begin
      sreg_next = data;
      cnt_next  = 7'h00;
      len_next  = nbits;
      crc_next  = 8'h00;
      busy_next = 1'b1;
    end
    else if (busy_reg)
    begin
      sreg_next = {sreg_reg[MAX_BITS-2:0], 1'b0};
      crc_next  = {crc_reg[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      cnt_next  = cnt_reg + 7'h01;
      busy_next = (cnt_reg + 7'h01) < len_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sreg_reg <= '0;
      cnt_reg  <= 7'h00;
      len_reg  <= 7'h00;
      crc_reg  <= 8'h00;
      busy_reg <= 1'b0;
    end
    else
    begin
      sreg_reg <= sreg_next;
      cnt_reg  <= cnt_next;
      len_reg  <= len_next;
      crc_reg  <= crc_next;
      busy_reg <= busy_next;
    end
  end

  assign crc  = crc_reg;
  assign done = !busy_reg;

endmodule

// ==== verilog/qar_serial_slave.sv ====
// Serial slave of a quad simultaneous-sampling converter
`timescale 1ns/1ns
module qar_serial_slave (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  cs_n_pin,
  input  wire logic                  sclk_pin,
  input  wire logic                  sdi_pin,
  input  wire qar_pkg::qar_results_t conv_data,
  output qar_pkg::qar_lanes_t        lane_out,
  output logic                       lane_oe,
  output logic                       conv_start,
  output qar_pkg::qar_cfg_t          cfg
);
  import qar_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] cs_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] sdi_sync_reg;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_sync_reg   <= 3'h7;
      sclk_sync_reg <= 3'h0;
      sdi_sync_reg  <= 2'h0;
    end
    else
    begin
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_pin};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi_pin};
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_fall   = !cs_sync_reg[1] && cs_sync_reg[2];
  assign cs_rise   = cs_sync_reg[1] && !cs_sync_reg[2];
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];

  // ----------------------------------------------------------------
  // Conversion timing and result capture
  // ----------------------------------------------------------------
  qar_results_t latest_reg;
  qar_results_t latest_next;
  logic [7:0]   conv_cnt_reg;
  logic [7:0]   conv_cnt_next;
  logic         conv_busy_reg;
  logic         conv_busy_next;
  logic         conv_start_reg;
  logic         conv_start_next;

  always_comb
  begin
    latest_next     = latest_reg;
    conv_cnt_next   = conv_cnt_reg;
    conv_busy_next  = conv_busy_reg;
    conv_start_next = cs_fall;
    if (cs_fall)
    begin
      conv_busy_next = 1'b1;
      conv_cnt_next  = 8'(CONV_CYCLES - 1);
    end
    else if (conv_busy_reg)
    begin
      if (conv_cnt_reg == 8'h00)
      begin
        latest_next    = conv_data;
        conv_busy_next = 1'b0;
      end
      else
        conv_cnt_next = conv_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latest_reg     <= '0;
      conv_cnt_reg   <= 8'h00;
      conv_busy_reg  <= 1'b0;
      conv_start_reg <= 1'b0;
    end
    else
    begin
      latest_reg     <= latest_next;
      conv_cnt_reg   <= conv_cnt_next;
      conv_busy_reg  <= conv_busy_next;
      conv_start_reg <= conv_start_next;
    end
  end

  // ----------------------------------------------------------------
  // Checksum engines: read side and write check
  // ----------------------------------------------------------------
  logic        rd_crc_start;
  logic [63:0] rd_crc_data;
  logic [6:0]  rd_crc_len;
  logic [7:0]  rd_crc;
  logic        wr_crc_start;
  logic [7:0]  wr_crc;
  logic        wr_crc_done;
  logic [15:0] wcmd_reg;
  logic [15:0] wcmd_next;

  qar_crc_serial #(.MAX_BITS(64)) u_rd_crc (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (rd_crc_start),
    .data    (rd_crc_data),
    .nbits   (rd_crc_len),
    .crc     (rd_crc),
    .done    ()
  );

  qar_crc_serial #(.MAX_BITS(16)) u_wr_crc (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (wr_crc_start),
    .data    (wcmd_next),
    .nbits   (LEN_FOUR),
    .crc     (wr_crc),
    .done    (wr_crc_done)
  );

  // ----------------------------------------------------------------
  // Frame, command decode and register file
  // ----------------------------------------------------------------
  qar_state_t  state_reg, state_next;
  logic [6:0]  bit_cnt_reg, bit_cnt_next;
  logic [4:0]  in_cnt_reg, in_cnt_next;
  logic [23:0] cmd_reg, cmd_next;
  logic [7:0]  wcrc_rx_reg, wcrc_rx_next;
  logic        wlong_reg, wlong_next;
  logic [63:0] sa_reg, sa_next;
  logic [31:0] sb_reg, sb_next;
  logic [15:0] sc_reg, sc_next;
  logic [15:0] sd_reg, sd_next;
  logic [6:0]  len_reg, len_next;
  logic        rd_pend_reg, rd_pend_next;
  logic [2:0]  rd_addr_reg, rd_addr_next;
  logic [11:0] cfg1_reg, cfg1_next;
  logic [11:0] cfg2_reg, cfg2_next;
  logic [11:0] low_reg, low_next;
  logic [11:0] high_reg, high_next;
  logic        crcw_fail_reg, crcw_fail_next;
  qar_lanes_t  lane_reg, lane_next;
  logic        oe_reg, oe_next;
  logic        wr_need;
  logic        wr_ok;
  logic [1:0]  lane_mode;
  logic [15:0] rd_word;
  logic [6:0]  crc_off;

  assign lane_mode = cfg2_reg[CFG2_LANE_LSB +: 2];
  assign wr_need   = cfg1_reg[CFG1_CRC_W_BIT] ||
                     (wcmd_reg[14:12] == ADDR_CFG1 && wcmd_reg[CFG1_CRC_W_BIT]);
  assign wr_ok     = !wr_need || (wlong_reg && wr_crc == wcrc_rx_reg);

  // Register read-back word: address nibble then data
  always_comb
  begin
    case (rd_addr_reg)
      ADDR_CFG1:  rd_word = {1'b0, rd_addr_reg, cfg1_reg};
      ADDR_CFG2:  rd_word = {1'b0, rd_addr_reg, cfg2_reg};
      ADDR_ALERT: rd_word = {1'b0, rd_addr_reg, 12'(crcw_fail_reg) << ALERT_CRCW_BIT};
      ADDR_LOW:   rd_word = {1'b0, rd_addr_reg, low_reg};
      ADDR_HIGH:  rd_word = {1'b0, rd_addr_reg, high_reg};
      default:    rd_word = 16'h0000;
    endcase
  end

  // Frame sequencing, shifting and command handling
  always_comb
  begin
    state_next     = state_reg;
    bit_cnt_next   = bit_cnt_reg;
    in_cnt_next    = in_cnt_reg;
    cmd_next       = cmd_reg;
    wcmd_next      = wcmd_reg;
    wcrc_rx_next   = wcrc_rx_reg;
    wlong_next     = wlong_reg;
    sa_next        = sa_reg;
    sb_next        = sb_reg;
    sc_next        = sc_reg;
    sd_next        = sd_reg;
    len_next       = len_reg;
    rd_pend_next   = rd_pend_reg;
    rd_addr_next   = rd_addr_reg;
    cfg1_next      = cfg1_reg;
    cfg2_next      = cfg2_reg;
    low_next       = low_reg;
    high_next      = high_reg;
    crcw_fail_next = crcw_fail_reg;
    rd_crc_start   = 1'b0;
    rd_crc_data    = {latest_reg.a, latest_reg.b, latest_reg.c, latest_reg.d};
    rd_crc_len     = LEN_ONE;
    wr_crc_start   = 1'b0;
    case (state_reg)
      ST_IDLE, ST_CHECK:
      begin
        if (state_reg == ST_CHECK && wr_crc_done)
        begin
          state_next = ST_IDLE;
          if (wr_ok)
          begin
            case (wcmd_reg[14:12])
              ADDR_CFG1: cfg1_next = wcmd_reg[11:0];
              ADDR_CFG2: cfg2_next = wcmd_reg[11:0];
              ADDR_LOW:  low_next  = wcmd_reg[11:0];
              ADDR_HIGH: high_next = wcmd_reg[11:0];
              default:   cfg1_next = cfg1_reg;
            endcase
          end
          else
            crcw_fail_next = 1'b1;
        end
        if (cs_fall)
        begin
          state_next   = ST_FRAME;
          bit_cnt_next = 7'h00;
          in_cnt_next  = 5'h00;
          rd_pend_next = 1'b0;
          rd_crc_start = 1'b1;
          sb_next      = 32'h0;
          sc_next      = 16'h0;
          sd_next      = 16'h0;
          if (rd_pend_reg && rd_addr_reg >= ADDR_CFG1 && rd_addr_reg <= ADDR_HIGH)
          begin
            sa_next     = {rd_word, 48'h0};
            len_next    = LEN_FOUR;
            rd_crc_data = {rd_word, 48'h0};
            rd_crc_len  = LEN_FOUR;
          end
          else
          begin
            case (lane_mode)
              LANE_FOUR:
              begin
                sa_next  = {latest_reg.a, 48'h0};
                sb_next  = {latest_reg.b, 16'h0};
                sc_next  = latest_reg.c;
                sd_next  = latest_reg.d;
                len_next = LEN_FOUR;
              end
              LANE_TWO:
              begin
                sa_next  = {latest_reg.a, latest_reg.c, 32'h0};
                sb_next  = {latest_reg.b, latest_reg.d};
                len_next = LEN_TWO;
              end
              default:
              begin
                sa_next  = latest_reg;
                len_next = LEN_ONE;
              end
            endcase
          end
        end
      end
      ST_FRAME:
      begin
        if (sclk_rise)
        begin
          sa_next = {sa_reg[62:0], 1'b0};
          sb_next = {sb_reg[30:0], 1'b0};
          sc_next = {sc_reg[14:0], 1'b0};
          sd_next = {sd_reg[14:0], 1'b0};
          if (bit_cnt_reg != 7'h7f)
            bit_cnt_next = bit_cnt_reg + 7'h01;
        end
        if (sclk_fall && in_cnt_reg < CMD_CRC_BITS)
        begin
          cmd_next    = {cmd_reg[22:0], sdi_sync_reg[1]};
          in_cnt_next = in_cnt_reg + 5'h01;
        end
        if (cs_rise)
        begin
          state_next = ST_IDLE;
          if (in_cnt_reg >= CMD_BITS)
          begin
            wlong_next   = in_cnt_reg >= CMD_CRC_BITS;
            wcmd_next    = wlong_next ? cmd_reg[23:8] : cmd_reg[15:0];
            wcrc_rx_next = cmd_reg[7:0];
            if (!wcmd_next[CMD_WR_BIT])
            begin
              rd_pend_next = 1'b1;
              rd_addr_next = wcmd_next[14:12];
            end
            else
            begin
              state_next   = ST_CHECK;
              wr_crc_start = 1'b1;
            end
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Lane drive from the next shift state
  always_comb
  begin
    crc_off   = bit_cnt_next - len_next;
    oe_next   = state_next == ST_FRAME;
    lane_next = '0;
    if (oe_next)
    begin
      lane_next.serial_out_lane_b = sb_next[31];
      lane_next.serial_out_lane_c = sc_next[15];
      lane_next.serial_out_lane_d = sd_next[15];
      if (bit_cnt_next < len_next)
        lane_next.serial_out_lane_a = sa_next[63];
      else if (cfg1_reg[CFG1_CRC_R_BIT] && crc_off < LEN_CRC)
        lane_next.serial_out_lane_a = rd_crc[3'(~crc_off[2:0])];
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 7'h00;
      in_cnt_reg    <= 5'h00;
      cmd_reg       <= 24'h0;
      wcmd_reg      <= 16'h0;
      wcrc_rx_reg   <= 8'h00;
      wlong_reg     <= 1'b0;
      sa_reg        <= 64'h0;
      sb_reg        <= 32'h0;
      sc_reg        <= 16'h0;
      sd_reg        <= 16'h0;
      len_reg       <= LEN_FOUR;
      rd_pend_reg   <= 1'b0;
      rd_addr_reg   <= 3'h0;
      cfg1_reg      <= RST_CFG1;
      cfg2_reg      <= RST_CFG2;
      low_reg       <= RST_LOW;
      high_reg      <= RST_HIGH;
      crcw_fail_reg <= 1'b0;
      lane_reg      <= '0;
      oe_reg        <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      in_cnt_reg    <= in_cnt_next;
      cmd_reg       <= cmd_next;
      wcmd_reg      <= wcmd_next;
      wcrc_rx_reg   <= wcrc_rx_next;
      wlong_reg     <= wlong_next;
      sa_reg        <= sa_next;
      sb_reg        <= sb_next;
      sc_reg        <= sc_next;
      sd_reg        <= sd_next;
      len_reg       <= len_next;
      rd_pend_reg   <= rd_pend_next;
      rd_addr_reg   <= rd_addr_next;
      cfg1_reg      <= cfg1_next;
      cfg2_reg      <= cfg2_next;
      low_reg       <= low_next;
      high_reg      <= high_next;
      crcw_fail_reg <= crcw_fail_next;
      lane_reg      <= lane_next;
      oe_reg        <= oe_next;
    end
  end

  assign lane_out   = lane_reg;
  assign lane_oe    = oe_reg;
  assign conv_start = conv_start_reg;
  assign cfg        = {cfg1_reg[CFG1_CRC_W_BIT], cfg1_reg[CFG1_CRC_R_BIT], lane_mode};

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic conv_frame;
  logic oe_d_reg;
  logic pend_d_reg;

  // Previous drive and read-pending state, for the frame-start checks
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oe_d_reg   <= 1'b0;
      pend_d_reg <= 1'b0;
    end
    else
    begin
      oe_d_reg   <= oe_reg;
      pend_d_reg <= rd_pend_reg;
    end
  end

  // Conversion frame begins: drive just rose and no register read pending
  assign conv_frame = oe_reg && !oe_d_reg && !pend_d_reg;

  four_lane_a: assert property (conv_frame && lane_mode == LANE_FOUR |->
    lane_reg.serial_out_lane_b == $past(latest_reg.b[15]) &&
    lane_reg.serial_out_lane_d == $past(latest_reg.d[15]))
    else $error("four lane start bits wrong");
  two_lane_a: assert property (conv_frame && lane_mode == LANE_TWO |->
    lane_reg.serial_out_lane_b == $past(latest_reg.b[15]) && !lane_reg.serial_out_lane_c)
    else $error("two lane start bits wrong");
  one_lane_a: assert property (conv_frame && lane_mode == LANE_ONE |->
    lane_reg.serial_out_lane_a == $past(latest_reg.a[15]) && !lane_reg.serial_out_lane_b)
    else $error("single lane start bits wrong");
  conv_start_a: assert property (cs_fall |=> conv_start_reg ##1 !conv_start_reg)
    else $error("conversion start pulse missing");
  conv_done_a: assert property (conv_start_reg |-> ##[1:20] !conv_busy_reg)
    else $error("conversion never completes");
  release_oe_a: assert property (cs_rise |=> !oe_reg)
    else $error("lanes still driven after select rise");
  read_pend_a: assert property (state_reg == ST_FRAME && cs_rise && in_cnt_reg >= CMD_BITS
    && !wcmd_next[CMD_WR_BIT] |=> rd_pend_reg)
    else $error("read command not registered");
  bad_write_a: assert property (state_reg == ST_CHECK && wr_crc_done && !wr_ok |=>
    $stable(cfg1_reg) && $stable(cfg2_reg) && crcw_fail_reg)
    else $error("write with bad checksum applied");
  good_write_a: assert property (state_reg == ST_CHECK && wr_crc_done && wr_ok
    && wcmd_reg[14:12] == ADDR_CFG2 |=> cfg2_reg == $past(wcmd_reg[11:0]))
    else $error("valid write not loaded");
  crc_lane_a: assert property (oe_reg && cfg1_reg[CFG1_CRC_R_BIT] && bit_cnt_reg == len_reg
    && $stable(cfg1_reg) |-> lane_reg.serial_out_lane_a == rd_crc[7])
    else $error("read checksum first bit wrong");

  four_frame_c: cover property (conv_frame && lane_mode == LANE_FOUR);
  crc_write_c:  cover property (state_reg == ST_CHECK && wr_crc_done && wr_ok && wr_need);
  reg_read_c:   cover property ($rose(oe_reg) && $past(rd_pend_reg));

endmodule

// ==== verif/qar_host_model.sv ====
// Host serial master model: drives frames, captures the four lanes
`timescale 1ns/1ns
module qar_host_model (
  output logic                cs_n,
  output logic                sclk,
  output logic                sdi,
  input  qar_pkg::qar_lanes_t lane
);
  import qar_pkg::*;
  logic [79:0] cap [4];
  event        done;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // One frame of n clocks, command MSB first, lanes read before each rise
  task automatic frame(input int n, input logic [23:0] cmd);
    foreach (cap[k]) cap[k] = '0;
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++)
    begin
      #100 sdi = (i < 24) ? cmd[23-i] : 1'b0;
      #100;
      foreach (cap[k]) cap[k] = {cap[k][78:0], lane[3-k]};
      sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    #200 cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale value
    -> done;
    #1600; // Gap past the conversion time
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the quad readout serial slave
`timescale 1ns/1ns
module tb;
  import qar_pkg::*;
  typedef struct {logic [79:0] e [4]; int k;} qar_note_t;
  logic         clock = 1'b0;
  logic         reset_n = 1'b0;
  qar_results_t conv_data, prv, cur;
  qar_lanes_t   lane_out;
  logic         lane_oe, conv_start, cs_n, sclk, sdi;
  qar_cfg_t     cfg;
  logic [11:0]  rg [8];
  logic [15:0]  rv;
  logic [1:0]   mode = LANE_TWO;
  logic [1:0]   md [3] = '{LANE_FOUR, LANE_TWO, LANE_ONE};
  logic [31:0]  seed = 32'hf027;
  bit           crcr, pend, first = 1'b1;
  int           failures, tests_run, starts;
  qar_note_t    q [$];
  always #25 clock = ~clock;
  qar_serial_slave i_qar_serial_slave (.clock(clock), .reset_n(reset_n), .cs_n_pin(cs_n),
    .sclk_pin(sclk), .sdi_pin(sdi), .conv_data(conv_data), .lane_out(lane_out),
    .lane_oe(lane_oe), .conv_start(conv_start), .cfg(cfg));
  qar_host_model i_qar_host_model (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .lane(lane_out));
  // Count conversion start pulses away from the launching edge
  always @(negedge clock)
    if (conv_start === 1'b1)
      starts++;
  function automatic logic [63:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {seed, ~seed};
  endfunction
  // Serial checksum, top byte inverted
  function automatic logic [7:0] crc8(input logic [63:0] d, input int w);
    logic [7:0] s;
    logic       b;
    s = 8'h00;
    for (int i = w - 1; i >= 0; i--)
    begin
      b = d[i] ^ (i >= w - 8) ^ s[7];
      s = {s[6:0], 1'b0} ^ (b ? CRC_POLY : 8'h00);
    end
    return s;
  endfunction
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    tests_run++;
    if (e !== g)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One frame: note the expected lanes, run it, then advance the converter
  task automatic xfer(input logic [23:0] cmd, input int n = 0);
    qar_note_t  t;
    logic [7:0] c;
    int         m;
    int         s;
    m = (mode == LANE_FOUR) ? 16 : (mode == LANE_TWO) ? 32 : 64;
    if (n == 0) n = m + (crcr ? 8 : 0);
    c = crcr ? crc8(prv, 64) : 8'h00;
    t.k = first ? 0 : pend ? 1 : 2;
    t.e[0] = pend ? {rv, crcr ? crc8(64'(rv), 16) : 8'h00, 56'h0} : (m == 16) ?
      {prv.a, c, 56'h0} : (m == 32) ? {prv.a, prv.c, c, 40'h0} : {prv, c, 8'h0};
    t.e[1] = (m == 16) ? {prv.b, 64'h0} : (m == 32) ? {prv.b, prv.d, 48'h0} : 80'h0;
    t.e[2] = (m == 16) ? {prv.c, 64'h0} : 80'h0;
    t.e[3] = (m == 16) ? {prv.d, 64'h0} : 80'h0;
    foreach (t.e[i]) t.e[i] = t.e[i] >> (80 - n);
    q.push_back(t);
    s = starts;
    i_qar_host_model.frame(n, cmd);
    chk("starts", 80'(starts - s), 80'h1);
    chk("oe off", 80'(lane_oe), 80'h0);
    pend = !cmd[23] && cmd[22:20] inside {[1:5]};
    rv = {1'b0, cmd[22:20], rg[cmd[22:20]]};
    first = 1'b0;
    prv = cur;
    cur = rnd();
    conv_data = cur;
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d, input logic [7:0] x = 0);
    logic [15:0] w;
    w = {1'b1, a, d};
    xfer({w, crc8(64'(w), 16) ^ x});
  endtask
  task automatic end_of_test();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare each finished frame after the first against the oldest note (lane a only after a register read)
  always @(i_qar_host_model.done)
  begin
    qar_note_t t;
    t = q.pop_front();
    chk("oe on", 80'(lane_oe), 80'h1);
    for (int i = 0; i < 4; i++)
      if (t.k == 2 || (t.k == 1 && i == 0))
        chk("lane", t.e[i], i_qar_host_model.cap[i]);
  end
  initial
  begin
    #3000000;
    failures++;
    end_of_test();
  end
  initial
  begin
    logic [63:0] r;
    rg = '{12'h0, RST_CFG1, RST_CFG2, 12'h0, RST_LOW, RST_HIGH, 12'h0, 12'h0};
    cur = rnd();
    conv_data = cur;
    repeat (5) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clock);
    #1 chk("cfg", 80'(cfg), 80'h0);
    r = rnd();
    xfer({1'b0, ADDR_LOW, r[19:0]});
    xfer({1'b0, ADDR_HIGH, 20'h0});
    xfer(24'h0);
    $display("test register read done");
    for (int k = 0; k < 2; k++)
    begin
      foreach (md[j])
      begin
        wr(ADDR_CFG2, {2'b00, md[j], 8'h00});
        mode = md[j];
        chk("mode", 80'(cfg.output_lane_select), 80'(mode));
      end
      wr(ADDR_CFG1, 12'h010);
      crcr = 1'b1;
    end
    wr(ADDR_CFG2, 12'h200);
    mode = LANE_FOUR;
    $display("test lane modes done");
    wr(ADDR_CFG1, 12'h030);
    chk("crc w on", 80'(cfg), 80'he);
    wr(ADDR_CFG1, 12'h010, 8'h01);
    chk("crc w kept", 80'(cfg), 80'he);
    rg[3] = 12'h200;
    xfer({1'b0, ADDR_ALERT, 20'h0});
    wr(ADDR_CFG1, 12'h010);
    chk("crc w off", 80'(cfg), 80'h6);
    xfer({1'b1, ADDR_CFG2, 20'h0}, 8);
    chk("short", 80'(cfg), 80'h6);
    xfer(24'h0);
    $display("test checksum writes done");
    end_of_test();
  end
endmodule
